//--- dio_event_mux.v
// event pin multiplexer and continuous-mode synchronous bit port
// assumes status flags come from logic on clk; only event_pin_2 input is external
`timescale 1ns/100ps
`include "dio_mux_regs.vh"

module dio_event_mux #(
	parameter HALF_CYC = `BIT_HALF_CYC,
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter CNT_W = `FIFO_CNT_W
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// configuration
	input wire [7:0] pinFunctionSelectA,
	input wire [7:0] pinFunctionSelectB,
	input wire continuousMode,
	input wire [2:0] opMode,
	input wire bitSyncEnable,
	input wire rcClockSelected,
	// internal status sources
	input wire patternMatchFlag,
	input wire transmitGoFlag,
	input wire receiveGoFlag,
	input wire rssiPreambleFlag,
	input wire payloadCompleteFlag,
	input wire checksumGoodFlag,
	input wire fillThresholdFlag,
	input wire [CNT_W-1:0] fifoCount,
	input wire thermalShiftFlag,
	input wire supplyLowFlag,
	input wire stateSettledFlag,
	input wire synthLockedFlag,
	input wire timeoutFlag,
	input wire referenceClockOutput,
	input wire txLastBitSent,
	// modem bit paths
	input wire demodBit,
	input wire packetTxBit,
	output reg modBit,
	output reg packetRxBit,
	// block enables and frame-sent flag
	output reg packetHandlerEnable,
	output reg fifoAccessEnable,
	output reg bitSyncActive,
	output reg framesentFlag,
	// pins
	output reg eventPin0,
	output reg eventPin1,
	input wire eventPin2In,
	output reg eventPin2Out,
	output reg eventPin2Oe,
	output reg eventPin3,
	output reg eventPin4,
	output reg eventPin5
);

	// operating state decode
	wire inSleep = (opMode == `OPM_SLEEP);
	wire inRx = (opMode == `OPM_RX);
	wire inTx = (opMode == `OPM_TX);
	wire inRxTx = inRx | inTx;
	wire pllOn = inRxTx | (opMode == `OPM_FS);
	wire pktMode = ~continuousMode;

	wire [1:0] sel0 = pinFunctionSelectA[`SELA_PIN0_HI:`SELA_PIN0_LO];
	wire [1:0] sel1 = pinFunctionSelectA[`SELA_PIN1_HI:`SELA_PIN1_LO];
	wire [1:0] sel2 = pinFunctionSelectA[`SELA_PIN2_HI:`SELA_PIN2_LO];
	wire [1:0] sel3 = pinFunctionSelectA[`SELA_PIN3_HI:`SELA_PIN3_LO];
	wire [1:0] sel4 = pinFunctionSelectB[`SELB_PIN4_HI:`SELB_PIN4_LO];
	wire [1:0] sel5 = pinFunctionSelectB[`SELB_PIN5_HI:`SELB_PIN5_LO];

	// pin2 input from the host: two flops before any use
	reg pinSync1_r;
	reg pinSync2_r;
	always @(posedge clk) begin
		if (srst) begin
			pinSync1_r <= 1'b0;
			pinSync2_r <= 1'b0;
		end else begin
			pinSync1_r <= eventPin2In;
			pinSync2_r <= pinSync1_r;
		end
	end

	// synchronizer forced on in packet mode
	wire syncOn = bitSyncEnable | pktMode;

	// demodulator edge detect drives clock recovery
	reg demodPrev_r;
	always @(posedge clk) begin
		if (srst) begin
			demodPrev_r <= 1'b0;
		end else begin
			demodPrev_r <= demodBit;
		end
	end
	wire demodEdge = demodBit ^ demodPrev_r;

	// bit clock runs in continuous-mode transmit, and in receive only with the synchronizer
	wire clkRun = (continuousMode & inTx) | (inRx & syncOn);
	wire clkResync = inRx & demodEdge;
	wire bitClk;
	wire bitRise;
	wire bitFall;

	bit_timer #(
		.HALF_CYC(HALF_CYC),
		.CNT_W(8)
	) u_bit_timer (
		.clk(clk),
		.srst(srst),
		.run(clkRun),
		.resync(clkResync),
		.clkLevel(bitClk),
		.risePulse(bitRise),
		.fallPulse(bitFall)
	);

	// cleaned receive data, updated only on the falling bit clock edge
	reg cleanBit_r;
	always @(posedge clk) begin
		if (srst) begin
			cleanBit_r <= 1'b0;
		end else if (inRx && bitFall) begin
			cleanBit_r <= demodBit;
		end
	end
	// pass on the bit being captured now, so pin2 moves with the pin1 falling edge
	wire cleanNow = (inRx && bitFall) ? demodBit : cleanBit_r;
	wire rxDataBit = syncOn ? cleanNow : demodBit;

	// host transmit data sampled at the rising bit clock edge; the host must keep
	// it stable ahead of that edge, since a two-flop delay sits in front of it
	reg hostTxBit_r;
	always @(posedge clk) begin
		if (srst) begin
			hostTxBit_r <= 1'b0;
		end else if (continuousMode && inTx && bitRise) begin
			hostTxBit_r <= pinSync2_r;
		end
	end

	// frame sent: set on the last shifted bit, dropped when leaving transmit
	reg frameSent_r;
	always @(posedge clk) begin
		if (srst) begin
			frameSent_r <= 1'b0;
		end else if (pktMode && inTx && txLastBitSent) begin
			frameSent_r <= 1'b1;
		end else if (!inTx || continuousMode) begin
			frameSent_r <= 1'b0;
		end
	end

	wire bufPacked = (fifoCount == FIFO_DEPTH[CNT_W-1:0]);
	wire bufVacant = (fifoCount == {CNT_W{1'b0}});
	wire thermSupply = thermalShiftFlag | supplyLowFlag;
	wire refClk = inSleep ? (referenceClockOutput & rcClockSelected) : referenceClockOutput;

	// pin function selection; every branch not listed drives low, except packet-mode pin3, whose default is the buffer-empty state
	reg pin0_nxt;
	reg pin1_nxt;
	reg pin2_nxt;
	reg pin2Oe_nxt;
	reg pin3_nxt;
	reg pin4_nxt;
	reg pin5_nxt;

	always @* begin
		pin0_nxt = 1'b0;
		pin1_nxt = 1'b0;
		pin2_nxt = 1'b0;
		pin2Oe_nxt = 1'b0;
		pin3_nxt = 1'b0;
		pin4_nxt = 1'b0;
		pin5_nxt = 1'b0;
		if (continuousMode) begin
			case (sel0)
				`MAP_00: pin0_nxt = (inRx & patternMatchFlag) | (inTx & transmitGoFlag);
				`MAP_01: pin0_nxt = inRx & rssiPreambleFlag;
				`MAP_10: pin0_nxt = (inRx & receiveGoFlag) | (inTx & transmitGoFlag);
				default: pin0_nxt = 1'b0;
			endcase
			case (sel1)
				`MAP_00: pin1_nxt = clkRun & bitClk;
				`MAP_01: pin1_nxt = inRx & rssiPreambleFlag;
				default: pin1_nxt = 1'b0;
			endcase
			// data pin: device drives in receive, host drives in transmit
			pin2_nxt = inRx & rxDataBit;
			pin2Oe_nxt = inRx;
			case (sel3)
				`MAP_00: pin3_nxt = inRx & timeoutFlag;
				`MAP_01: pin3_nxt = inRx & rssiPreambleFlag;
				`MAP_11: pin3_nxt = ~inSleep & thermSupply;
				default: pin3_nxt = 1'b0;
			endcase
			case (sel4)
				`MAP_00: pin4_nxt = inRxTx & thermSupply;
				`MAP_01: pin4_nxt = pllOn & synthLockedFlag;
				`MAP_10: pin4_nxt = inRx & timeoutFlag;
				`MAP_11: pin4_nxt = ~inSleep & stateSettledFlag;
				default: pin4_nxt = 1'b0;
			endcase
			case (sel5)
				`MAP_00: pin5_nxt = refClk;
				`MAP_01: pin5_nxt = pllOn & synthLockedFlag;
				`MAP_10: pin5_nxt = inRx & rssiPreambleFlag;
				`MAP_11: pin5_nxt = ~inSleep & stateSettledFlag;
				default: pin5_nxt = 1'b0;
			endcase
		end else begin
			case (sel0)
				`MAP_00: pin0_nxt = (inRx & payloadCompleteFlag) | (inTx & frameSent_r);
				`MAP_01: pin0_nxt = inRx & checksumGoodFlag;
				`MAP_11: pin0_nxt = ~inSleep & thermSupply;
				default: pin0_nxt = 1'b0;
			endcase
			case (sel1)
				`MAP_00: pin1_nxt = fillThresholdFlag;
				`MAP_01: pin1_nxt = bufVacant;
				`MAP_10: pin1_nxt = bufPacked;
				default: pin1_nxt = 1'b0;
			endcase
			// packet mode: pin2 is an event output, never the data path
			pin2Oe_nxt = 1'b1;
			case (sel2)
				`MAP_00: pin2_nxt = bufPacked;
				`MAP_01: pin2_nxt = inRx & receiveGoFlag;
				`MAP_10: pin2_nxt = inRx ? timeoutFlag : bufPacked;
				`MAP_11: pin2_nxt = inRx ? patternMatchFlag : bufPacked;
				default: pin2_nxt = 1'b0;
			endcase
			case (sel3)
				`MAP_01: pin3_nxt = inTx & transmitGoFlag;
				default: pin3_nxt = bufVacant;
			endcase
			case (sel4)
				`MAP_00: pin4_nxt = ~inSleep & thermSupply;
				`MAP_01: pin4_nxt = pllOn & synthLockedFlag;
				`MAP_10: pin4_nxt = inRx & timeoutFlag;
				`MAP_11: pin4_nxt = inRx & rssiPreambleFlag;
				default: pin4_nxt = 1'b0;
			endcase
			case (sel5)
				`MAP_00: pin5_nxt = refClk;
				`MAP_01: pin5_nxt = pllOn & synthLockedFlag;
				`MAP_10: pin5_nxt = inRx & rxDataBit;
				`MAP_11: pin5_nxt = ~inSleep & stateSettledFlag;
				default: pin5_nxt = 1'b0;
			endcase
		end
	end

	// registered pins and bit paths
	always @(posedge clk) begin
		if (srst) begin
			eventPin0 <= 1'b0;
			eventPin1 <= 1'b0;
			eventPin2Out <= 1'b0;
			eventPin2Oe <= 1'b0;
			eventPin3 <= 1'b0;
			eventPin4 <= 1'b0;
			eventPin5 <= 1'b0;
			modBit <= 1'b0;
			packetRxBit <= 1'b0;
			packetHandlerEnable <= 1'b0;
			fifoAccessEnable <= 1'b0;
			bitSyncActive <= 1'b0;
			framesentFlag <= 1'b0;
		end else begin
			eventPin0 <= pin0_nxt;
			eventPin1 <= pin1_nxt;
			eventPin2Out <= pin2_nxt;
			eventPin2Oe <= pin2Oe_nxt;
			eventPin3 <= pin3_nxt;
			eventPin4 <= pin4_nxt;
			eventPin5 <= pin5_nxt;
			// modulator takes host bits directly, or the buffer path
			modBit <= continuousMode ? hostTxBit_r : packetTxBit;
			packetRxBit <= pktMode & inRx & cleanBit_r;
			packetHandlerEnable <= pktMode;
			// buffer access is not tied to transmit or receive state
			fifoAccessEnable <= pktMode;
			bitSyncActive <= syncOn;
			framesentFlag <= frameSent_r;
		end
	end

endmodule

//--- dio_mux_regs.vh
// constants for the pin function multiplexer and continuous bit port
// included by dio_event_mux.v and bit_timer.v; definitions only
`ifndef DIO_MUX_REGS_VH
`define DIO_MUX_REGS_VH

// operating state codes, as presented by the mode controller
`define OPM_SLEEP 3'h0
`define OPM_STDBY 3'h1
`define OPM_FS 3'h2
`define OPM_TX 3'h3
`define OPM_RX 3'h4

// 2-bit pin function codes
`define MAP_00 2'h0
`define MAP_01 2'h1
`define MAP_10 2'h2
`define MAP_11 2'h3

// field positions inside pin_function_select_a
`define SELA_PIN0_HI 7
`define SELA_PIN0_LO 6
`define SELA_PIN1_HI 5
`define SELA_PIN1_LO 4
`define SELA_PIN2_HI 3
`define SELA_PIN2_LO 2
`define SELA_PIN3_HI 1
`define SELA_PIN3_LO 0
// field positions inside pin_function_select_b
`define SELB_PIN4_HI 7
`define SELB_PIN4_LO 6
`define SELB_PIN5_HI 5
`define SELB_PIN5_LO 4

// timing: clock period and half bit period in ns
`define CLK_PERIOD_NS 100
`define BIT_HALF_NS 400
`define BIT_HALF_CYC (`BIT_HALF_NS / `CLK_PERIOD_NS)

// buffer size and counter width
`define FIFO_DEPTH 64
`define FIFO_CNT_W 7

`endif

//--- bit_timer.v
// half-bit timer that makes the bit clock level and its edge enables
// runs on the single system clock; resync realigns to a data transition
`timescale 1ns/100ps
`include "dio_mux_regs.vh"

module bit_timer #(
	parameter HALF_CYC = `BIT_HALF_CYC,
	parameter CNT_W = 8
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// control
	input wire run,
	input wire resync,
	// bit clock
	output reg clkLevel,
	output reg risePulse,
	output reg fallPulse
);

	reg [CNT_W-1:0] cnt_r;
	localparam [CNT_W-1:0] LAST = HALF_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge clk) begin
		if (srst || !run) begin
			cnt_r <= {CNT_W{1'b0}};
			clkLevel <= 1'b0;
			risePulse <= 1'b0;
			fallPulse <= 1'b0;
		end else if (resync) begin
			// restart the bit with the clock high, so the falling edge lands mid-bit
			cnt_r <= {CNT_W{1'b0}};
			clkLevel <= 1'b1;
			risePulse <= 1'b0;
			fallPulse <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= {CNT_W{1'b0}};
			clkLevel <= ~clkLevel;
			risePulse <= ~clkLevel;
			fallPulse <= clkLevel;
		end else begin
			cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			risePulse <= 1'b0;
			fallPulse <= 1'b0;
		end
	end

endmodule

//--- dio_event_mux_properties.sv
// timing checker for the event pin multiplexer, bound to dio_event_mux
// assumes all selects and flags are levels sampled on clk
`timescale 1ns/100ps
module dio_event_mux_properties #(
	parameter FIFO_DEPTH = 64,
	parameter CNT_W = 7
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// watched inputs
	input wire [7:0] pinFunctionSelectA,
	input wire continuousMode,
	input wire [2:0] opMode,
	input wire bitSyncEnable,
	input wire patternMatchFlag,
	input wire payloadCompleteFlag,
	input wire [CNT_W-1:0] fifoCount,
	input wire demodBit,
	input wire eventPin2In,
	// watched outputs
	input wire modBit,
	input wire bitSyncActive,
	input wire eventPin0,
	input wire eventPin1,
	input wire eventPin2Out,
	input wire eventPin2Oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	wire [1:0] code0 = pinFunctionSelectA[7:6];
	wire rxSync = continuousMode && opMode == 3'h4 && bitSyncEnable;
	property p_cont_pin0;
		continuousMode && opMode == 3'h4 && code0 == 2'h0 |=> eventPin0 == $past(patternMatchFlag);
	endproperty
	a_cont_pin0: assert property (p_cont_pin0) else $error("pin0 source wrong");
	property p_pkt_pin0;
		!continuousMode && opMode == 3'h4 && code0 == 2'h0 |=> eventPin0 == $past(payloadCompleteFlag);
	endproperty
	a_pkt_pin0: assert property (p_pkt_pin0) else $error("pin0 payload wrong");
	property p_unlisted;
		continuousMode && code0 == 2'h3 |=> !eventPin0;
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("pin0 not low");
	property p_sync_on;
		1'b1 |=> bitSyncActive == $past(bitSyncEnable || !continuousMode);
	endproperty
	a_sync_on: assert property (p_sync_on) else $error("sync enable wrong");
	property p_raw_rx;
		continuousMode && opMode == 3'h4 && !bitSyncEnable |=> eventPin2Oe && eventPin2Out == $past(demodBit);
	endproperty
	a_raw_rx: assert property (p_raw_rx) else $error("raw data wrong");
	property p_tx_sample;
		continuousMode && opMode == 3'h3 && $rose(eventPin1) |=> modBit == $past(eventPin2In, 4);
	endproperty
	a_tx_sample: assert property (p_tx_sample) else $error("tx sample wrong");
	property p_rx_fall;
		rxSync && $past(rxSync) && $past(rxSync, 2) && $changed(eventPin2Out) |-> $fell(eventPin1);
	endproperty
	a_rx_fall: assert property (p_rx_fall) else $error("rx data off fall");
	property p_full;
		!continuousMode && opMode <= 3'h4 && pinFunctionSelectA[5:4] == 2'h2
			|=> eventPin1 == ($past(fifoCount) == FIFO_DEPTH);
	endproperty
	a_full: assert property (p_full) else $error("full flag wrong");
endmodule
bind dio_event_mux dio_event_mux_properties #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) chk (
	.clk(clk), .srst(srst), .pinFunctionSelectA(pinFunctionSelectA),
	.continuousMode(continuousMode), .opMode(opMode), .bitSyncEnable(bitSyncEnable),
	.patternMatchFlag(patternMatchFlag), .payloadCompleteFlag(payloadCompleteFlag),
	.fifoCount(fifoCount), .demodBit(demodBit), .eventPin2In(eventPin2In), .modBit(modBit),
	.bitSyncActive(bitSyncActive), .eventPin0(eventPin0), .eventPin1(eventPin1),
	.eventPin2Out(eventPin2Out), .eventPin2Oe(eventPin2Oe)
);

//--- host_bit_source.sv
// host side of the continuous transmit bit port
// releases the data line itself (hostOe follows run) whenever run is low
`timescale 1ns/100ps
module host_bit_source (
	// control
	input wire run,
	input wire [15:0] pattern,
	// bit port
	input wire bitClock,
	output wire hostOe,
	output wire hostData
);
	reg [3:0] idx = 4'hf;
	// bits move on the falling clock so they are settled long before the rising sample
	always @(negedge bitClock or negedge run) begin
		if (!run) begin
			idx <= 4'hf;
		end else begin
			idx <= idx - 4'h1;
		end
	end
	assign hostOe = run;
	assign hostData = pattern[idx];
endmodule

//--- test_dio_event_mux.sv
// self-checking bench for the event pin multiplexer and bit port
// assumes HALF_CYC of 4, so one bit lasts 8 clk cycles
`timescale 1ns/100ps
module test_dio_event_mux;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg [7:0] selA = 8'h00;
	reg cont = 1'b0;
	reg [2:0] mode = 3'h1;
	reg bse = 1'b0;
	reg [15:0] f = 16'h0000;
	reg [6:0] cnt = 7'h00;
	reg txLast = 1'b0;
	reg demod = 1'b0;
	reg run = 1'b0;
	reg idle = 1'b0;
	reg p1 = 1'b0;
	reg p2 = 1'b0;
	reg [7:0] selB = 8'h00;
	integer errors = 0;
	integer checks = 0;
	integer cyc = 0;
	integer bits = 0;
	integer i;
	localparam [15:0] PAT = 16'ha5c3;
	wire modBit, bsa, phe, fae, pin0, pin1, pin2Out, pin2Oe, hostOe, hostData;
	wire prx, fsf, pin3, pin4, pin5;
	// a released line without pull shows a toggling level, never the last one
	wire pin2 = pin2Oe ? pin2Out : (hostOe ? hostData : idle);
	dio_event_mux #(.HALF_CYC(4)) DUT (
		.clk(clk), .srst(srst), .pinFunctionSelectA(selA), .pinFunctionSelectB(selB),
		.continuousMode(cont), .opMode(mode), .bitSyncEnable(bse), .rcClockSelected(f[13]),
		.patternMatchFlag(f[0]), .transmitGoFlag(f[1]), .receiveGoFlag(f[2]),
		.rssiPreambleFlag(f[3]), .payloadCompleteFlag(f[4]), .checksumGoodFlag(f[5]),
		.fillThresholdFlag(f[6]), .fifoCount(cnt), .thermalShiftFlag(f[7]),
		.supplyLowFlag(f[8]), .stateSettledFlag(f[9]), .synthLockedFlag(f[10]),
		.timeoutFlag(f[11]), .referenceClockOutput(f[12]), .txLastBitSent(txLast),
		.demodBit(demod), .packetTxBit(f[14]), .modBit(modBit), .packetRxBit(prx),
		.packetHandlerEnable(phe), .fifoAccessEnable(fae), .bitSyncActive(bsa),
		.framesentFlag(fsf), .eventPin0(pin0), .eventPin1(pin1), .eventPin2In(pin2),
		.eventPin2Out(pin2Out), .eventPin2Oe(pin2Oe), .eventPin3(pin3), .eventPin4(pin4),
		.eventPin5(pin5)
	);
	host_bit_source host (.run(run), .pattern(PAT), .bitClock(pin1), .hostOe(hostOe),
		.hostData(hostData));
	initial begin
		forever #50 clk = ~clk;
	end
	task check(input reg seen, input reg exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
			end
		end
	endtask
	task go(input [7:0] a, input c, input [2:0] m, input [15:0] v);
		begin
			selA <= a;
			cont <= c;
			mode <= m;
			f <= v;
			@(posedge clk);
			@(posedge clk);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d errors %0d", checks, errors);
			if (errors == 0 && checks > 0) begin
				$display("Test passed");
			end else begin
				$display("Test failed");
			end
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		idle <= ~idle;
		p1 <= pin1;
		p2 <= p1;
		// modBit follows the pin1 rise by one more cycle
		if (run && p1 && !p2) begin
			check(modBit, PAT[15-bits]);
			bits = bits + 1;
		end
		if (cyc == 2000) begin
			errors = errors + 1;
			test_done;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		go(8'h00, 1'b1, 3'h4, 16'h0001);
		check(pin0, 1'b1);
		go(8'h00, 1'b1, 3'h3, 16'h0002);
		check(pin0, 1'b1);
		go(8'h40, 1'b1, 3'h4, 16'h0008);
		check(pin0, 1'b1);
		go(8'h80, 1'b1, 3'h4, 16'h0004);
		check(pin0, 1'b1);
		go(8'h80, 1'b1, 3'h4, 16'h0001);
		check(pin0, 1'b0);
		go(8'hc0, 1'b1, 3'h4, 16'h7fff);
		check(pin0, 1'b0);
		go(8'h00, 1'b1, 3'h0, 16'h7fff);
		check(pin0, 1'b0);
		check(phe, 1'b0);
		check(pin5, 1'b1);
		check(pin4, 1'b0);
		go(8'h00, 1'b0, 3'h4, 16'h0010);
		check(pin0, 1'b1);
		check(bsa, 1'b1);
		go(8'h40, 1'b0, 3'h4, 16'h0020);
		check(pin0, 1'b1);
		go(8'h40, 1'b0, 3'h3, 16'h0020);
		check(pin0, 1'b0);
		go(8'hc0, 1'b0, 3'h1, 16'h0080);
		check(pin0, 1'b1);
		check(pin3, 1'b1);
		check(pin4, 1'b1);
		go(8'hc0, 1'b0, 3'h4, 16'h0100);
		check(pin0, 1'b1);
		go(8'h00, 1'b0, 3'h0, 16'h0000);
		check(fae, 1'b1);
		check(phe, 1'b1);
		selB <= 8'h40;
		go(8'h00, 1'b0, 3'h2, 16'h0400);
		check(pin4, 1'b1);
		$display("pin table done");
		cnt <= 7'h3f;
		go(8'h20, 1'b0, 3'h1, 16'h0000);
		check(pin1, 1'b0);
		cnt <= 7'h40;
		go(8'h20, 1'b0, 3'h1, 16'h0000);
		check(pin1, 1'b1);
		go(8'h00, 1'b0, 3'h3, 16'h0000);
		check(pin0, 1'b0);
		txLast <= 1'b1;
		@(posedge clk);
		txLast <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		check(pin0, 1'b1);
		check(fsf, 1'b1);
		$display("packet flags done");
		go(8'h00, 1'b1, 3'h4, 16'h0000);
		// an odd count leaves the raw line low, matching the held clean bit
		for (i = 0; i < 7; i = i + 1) begin
			demod <= i[0];
			@(posedge clk);
			@(posedge clk);
			check(pin2Out, i[0]);
			check(pin1, 1'b0);
		end
		bse <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			demod <= PAT[i+8];
			repeat (8) @(posedge clk);
			check(pin2Out, PAT[i+8]);
			check(prx, 1'b0);
		end
		$display("receive done");
		bse <= 1'b0;
		go(8'h00, 1'b1, 3'h1, 16'h0000);
		run <= 1'b1;
		go(8'h00, 1'b1, 3'h3, 16'h0000);
		repeat (118) @(posedge clk);
		check(pin2Oe, 1'b0);
		check(bits == 15, 1'b1);
		run <= 1'b0;
		go(8'h00, 1'b1, 3'h1, 16'h0000);
		$display("transmit done");
		test_done;
	end
endmodule
